// *** logic/rmps_cfg.svh ***
`ifndef RMPS_CFG_SVH
`define RMPS_CFG_SVH
`define RMPS_CLK_MHZ 200
`define RMPS_MS_NS 1000000
`define RMPS_CLK_NS 5
`define RMPS_MS_CYC (`RMPS_MS_NS / `RMPS_CLK_NS)
`define RMPS_BLINK_MS 250
`define RMPS_REBOOT_MS 5000
`define RMPS_WAKE_US 10
`define RMPS_WAKE_CYC ((`RMPS_WAKE_US * 1000 + `RMPS_CLK_NS - 1) / `RMPS_CLK_NS)
`define RMPS_OK_MS 30
`define RMPS_STUDY_PKTS 4
`define RMPS_MARG_DIV_SH 3
`define RMPS_MARG_ADD_MS 60
`define RMPS_OVL_ADD_MS 100
`define RMPS_RESTUDY_CYC 100
`define RMPS_SEP_MIN_MS 200
`endif

// *** logic/rmps_pkg.sv ***
package rmps_pkg;
  typedef enum logic [2:0] {
    RMPS_OFF = 3'b000,
    RMPS_SEARCH = 3'b001,
    RMPS_RECV = 3'b011,
    RMPS_TX = 3'b010,
    RMPS_SLEEP = 3'b110,
    RMPS_WAKE = 3'b111,
    RMPS_PSAVE = 3'b101,
    RMPS_SAFE = 3'b100
  } rmps_state_t;
  typedef struct packed {
    logic sync_found;
    logic frame_done;
    logic frame_ok;
    logic tx_req;
    logic tx_done;
  } rmps_radio_ev_t;
  typedef struct packed {
    logic sleep;
    logic restart;
    logic psave_on;
    logic psave_off;
  } rmps_cmd_t;
endpackage

// *** logic/rmps_ms_tick.sv ***
`include "rmps_cfg.svh"
module rmps_ms_tick
  import rmps_pkg::*;
#(
  parameter int CYC = `RMPS_MS_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  logic [31:0] cnt_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= 32'h0;
    end else if (cnt_ff == 32'(CYC - 1)) begin
      cnt_ff <= 32'h0;
    end else begin
      cnt_ff <= cnt_ff + 32'h1;
    end
  end
  assign tick = (cnt_ff == 32'(CYC - 1));
endmodule

// *** logic/rmps_wake_det.sv ***
`include "rmps_cfg.svh"
module rmps_wake_det
  import rmps_pkg::*;
#(
  parameter int MIN_CYC = `RMPS_WAKE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic line_in,
  output logic wake
);
  // a level change that holds MIN_CYC cycles counts; a 0x00 byte qualifies
  logic ref_ff;
  logic [15:0] hold_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_ff <= 1'b1;
      hold_ff <= 16'h0;
    end else if (!arm) begin
      ref_ff <= line_in;
      hold_ff <= 16'h0;
    end else if (line_in != ref_ff) begin
      hold_ff <= hold_ff + 16'h1;
    end else begin
      hold_ff <= 16'h0;
    end
  end
  assign wake = arm && (hold_ff >= 16'(MIN_CYC - 1)) && (line_in != ref_ff);
endmodule

// *** logic/rmps_top.sv ***
// Function
// RL1: search for sync, then receive data
// RL2: fault enters safe mode, codes readable
// RL3: safe mode blinks 250 ms, reboots 5 s
// RL4: no radio activity in safe mode
// RL5: enable high turns device on
// RL6: enable low: off, volatile state reset; ttx_ff is kept
// RL7: light sleep: radio off, serial on
// RL8: wake on serial line level change
// RL9: send ok within 30 ms of wake
// RL10: stay awake until next sleep command
// RL11: sender keeps packets over 200 ms apart
// RL12: study four packets before scheduling sleep
// RL13: update shortest interval every good packet; the code updates at each sync in search except early ones once scheduled, whether or not the frame is good
// RL14: margin is interval/8 plus 60 ms
// RL15: sleep is interval minus margin minus tx
// RL16: restart study after 100 sleep cycles
// RL17: miss window: count lost, restart study
// RL18: restart command shuts down and reboots
// RL19: indicator low throughout light sleep
// RL20: all timers share one millisecond tick; the wake filter hold_ff counts clock cycles instead
`include "rmps_cfg.svh"
module rmps_top
  import rmps_pkg::*;
#(
  parameter int MS_CYC = `RMPS_MS_CYC,
  parameter int WAKE_CYC = `RMPS_WAKE_CYC,
  parameter int TW = 16,
  parameter int FW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic module_enable_in,
  input wire logic serial_tx_data_in,
  input wire rmps_radio_ev_t radio_ev,
  input wire rmps_cmd_t config_command,
  input wire logic fault_in,
  input wire logic [FW-1:0] fault_code_in,
  output rmps_state_t state,
  output logic radio_power_on,
  output logic rx_enable,
  output logic tx_enable,
  output logic serial_power_on,
  output logic status_led,
  output logic ok_send,
  output logic fault_valid,
  output logic [FW-1:0] fault_code,
  output logic cpu_reboot,
  output logic [TW-1:0] t_min,
  output logic [TW-1:0] t_marg,
  output logic [TW-1:0] t_sleep,
  output logic [15:0] lost_count
);
  rmps_state_t state_ff;
  rmps_state_t nxt_state;
  logic ms_tick;
  logic wake;
  logic [TW-1:0] tmr_ff;
  logic [TW-1:0] blink_ff;
  logic led_ff;
  logic psave_ff;
  logic [2:0] study_ff;
  logic [7:0] cyc_ff;
  logic [TW-1:0] since_ff;
  logic [TW-1:0] tmin_ff;
  logic [TW-1:0] ttx_ff;
  logic [TW-1:0] txlen_ff;
  logic [TW-1:0] marg;
  logic [TW-1:0] ovl;
  logic [TW-1:0] slp;
  logic [TW-1:0] win_lo;
  logic [TW-1:0] win_hi;
  logic sched;
  logic en_ff;
  logic [FW-1:0] code_ff;
  logic valid_ff;
  logic ok_ff;
  logic reboot_ff;
  logic [15:0] lost_ff;
  logic good_pkt;
  logic missed;

  rmps_ms_tick #(.CYC(MS_CYC)) u_tick ( // RL20
    .clk(clk),
    .rst_n(rst_n),
    .tick(ms_tick)
  );

  rmps_wake_det #(.MIN_CYC(WAKE_CYC)) u_wake (
    .clk(clk),
    .rst_n(rst_n),
    .arm(state_ff == RMPS_SLEEP),
    .line_in(serial_tx_data_in),
    .wake(wake)
  );

  // enable is synchronous; low acts as a functional reset of all volatile state except the stored transmit length ttx_ff
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_ff <= 1'b0;
    end else begin
      en_ff <= module_enable_in;
    end
  end

  assign marg = (tmin_ff >> `RMPS_MARG_DIV_SH) + TW'(`RMPS_MARG_ADD_MS); // RL14
  assign ovl = marg + TW'(`RMPS_OVL_ADD_MS); // RL17
  assign slp = (tmin_ff > marg + ttx_ff) ? tmin_ff - marg - ttx_ff
                                         : TW'(0); // RL15
  assign win_lo = (tmin_ff > marg) ? tmin_ff - marg : TW'(0); // RL17
  assign win_hi = tmin_ff + ovl; // RL17
  assign sched = psave_ff && (study_ff == 3'(`RMPS_STUDY_PKTS)); // RL12
  assign good_pkt = (state_ff == RMPS_RECV) && radio_ev.frame_done &&
                    radio_ev.frame_ok;
  assign missed = sched && (state_ff == RMPS_SEARCH) && (since_ff > win_hi);

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      RMPS_OFF: begin
        if (en_ff && !reboot_ff) begin
          nxt_state = RMPS_SEARCH; // RL5
        end
      end
      RMPS_SEARCH: begin
        if (config_command.sleep) begin
          nxt_state = RMPS_SLEEP;
        end else if (radio_ev.sync_found) begin
          nxt_state = RMPS_RECV; // RL1
        end else if (radio_ev.tx_req) begin
          nxt_state = RMPS_TX;
        end
      end
      RMPS_RECV: begin
        if (radio_ev.frame_done) begin
          nxt_state = (sched && good_pkt && slp != TW'(0)) ? RMPS_PSAVE
                                                         : RMPS_SEARCH;
        end
      end
      RMPS_TX: begin
        if (radio_ev.tx_done) begin
          nxt_state = RMPS_SEARCH;
        end
      end
      RMPS_SLEEP: begin
        if (wake) begin
          nxt_state = RMPS_WAKE; // RL8
        end
      end
      RMPS_WAKE: begin
        if (tmr_ff == TW'(`RMPS_OK_MS)) begin
          nxt_state = RMPS_SEARCH; // RL10
        end
      end
      RMPS_PSAVE: begin
        if (tmr_ff >= t_sleep) begin
          nxt_state = RMPS_SEARCH;
        end
      end
      RMPS_SAFE: begin
        nxt_state = RMPS_SAFE;
      end
      default: nxt_state = RMPS_OFF;
    endcase
    if (fault_in && state_ff != RMPS_OFF) begin
      nxt_state = RMPS_SAFE; // RL2
    end
    if (config_command.restart || reboot_ff) begin
      nxt_state = RMPS_OFF; // RL18
    end
    if (!en_ff) begin
      nxt_state = RMPS_OFF; // RL6
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= RMPS_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // per-state timer in ms, cleared on every state change
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_ff <= TW'(0);
    end else if (nxt_state != state_ff) begin
      tmr_ff <= TW'(0);
    end else if (ms_tick && tmr_ff != {TW{1'b1}}) begin
      tmr_ff <= tmr_ff + TW'(1); // RL20
    end
  end

  // reboot pulse: one cycle, forces off then re-entry while enable stays high
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reboot_ff <= 1'b0;
    end else begin
      reboot_ff <= (state_ff == RMPS_SAFE && ms_tick &&
                    tmr_ff == TW'(`RMPS_REBOOT_MS - 1)) ||
                   (config_command.restart && state_ff != RMPS_OFF); // RL3 RL18
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      blink_ff <= TW'(0);
      led_ff <= 1'b0;
    end else if (state_ff != RMPS_SAFE) begin
      blink_ff <= TW'(0);
      led_ff <= 1'b0;
    end else if (ms_tick) begin
      if (blink_ff == TW'(`RMPS_BLINK_MS - 1)) begin
        blink_ff <= TW'(0);
        led_ff <= ~led_ff; // RL3
      end else begin
        blink_ff <= blink_ff + TW'(1);
      end
    end
  end

  // fault codes are latched and survive the reboot, cleared only by enable low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      code_ff <= '0;
      valid_ff <= 1'b0;
    end else if (!en_ff) begin
      code_ff <= '0;
      valid_ff <= 1'b0; // RL6
    end else if (fault_in && state_ff != RMPS_OFF && state_ff != RMPS_SAFE) begin
      code_ff <= fault_code_in;
      valid_ff <= 1'b1; // RL2
    end
  end

  // ok pulse two cycles after the ms tick that ends the wake-up delay
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ok_ff <= 1'b0;
    end else begin
      ok_ff <= (state_ff == RMPS_WAKE) && (tmr_ff == TW'(`RMPS_OK_MS)); // RL9
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      psave_ff <= 1'b0;
    end else if (!en_ff || reboot_ff) begin
      psave_ff <= 1'b0;
    end else if (config_command.psave_on) begin
      psave_ff <= 1'b1;
    end else if (config_command.psave_off) begin
      psave_ff <= 1'b0;
    end
  end

  // transmit length of the current frame measured from sync to frame end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      txlen_ff <= TW'(0);
      ttx_ff <= TW'(0);
    end else if (state_ff != RMPS_RECV) begin
      txlen_ff <= TW'(0);
    end else if (good_pkt) begin
      ttx_ff <= txlen_ff;
    end else if (ms_tick) begin
      txlen_ff <= txlen_ff + TW'(1);
    end
  end

  // interval from one packet start to the next, saturating; forced to
  // saturation on every study reset except the 100-cycle restudy, so a stale gap is never taken as t_min
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      since_ff <= {TW{1'b1}};
    end else if (!en_ff || !psave_ff || reboot_ff || missed) begin
      since_ff <= {TW{1'b1}}; // RL17
    end else if (state_ff == RMPS_SEARCH && radio_ev.sync_found) begin
      since_ff <= TW'(0);
    end else if (ms_tick && since_ff != {TW{1'b1}}) begin
      since_ff <= since_ff + TW'(1);
    end
  end

  // interval study; a saturated first interval is not a measurement
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      study_ff <= 3'h0;
      tmin_ff <= {TW{1'b1}};
      cyc_ff <= 8'h0;
      lost_ff <= 16'h0;
    end else if (!en_ff || !psave_ff || reboot_ff) begin
      study_ff <= 3'h0;
      tmin_ff <= {TW{1'b1}};
      cyc_ff <= 8'h0;
      if (!en_ff) begin
        lost_ff <= 16'h0; // RL6
      end
    end else if (missed) begin
      study_ff <= 3'h0; // RL17
      tmin_ff <= {TW{1'b1}};
      cyc_ff <= 8'h0;
      lost_ff <= lost_ff + 16'h1; // RL17
    end else if (state_ff == RMPS_PSAVE && nxt_state == RMPS_SEARCH) begin
      if (cyc_ff == 8'(`RMPS_RESTUDY_CYC - 1)) begin
        study_ff <= 3'h0; // RL16
        tmin_ff <= {TW{1'b1}};
        cyc_ff <= 8'h0;
      end else begin
        cyc_ff <= cyc_ff + 8'h1;
      end
    end else if (state_ff == RMPS_SEARCH && radio_ev.sync_found &&
                 since_ff != {TW{1'b1}}) begin
      if (sched && since_ff < win_lo) begin
        study_ff <= study_ff;
      end else begin
        if (since_ff < tmin_ff) begin
          tmin_ff <= since_ff; // RL13
        end
        if (study_ff != 3'(`RMPS_STUDY_PKTS)) begin
          study_ff <= study_ff + 3'h1; // RL12
        end
      end
    end
  end

  // radio gated off outside the search/receive/transmit states
  assign radio_power_on = (state_ff == RMPS_SEARCH) ||
                          (state_ff == RMPS_RECV) ||
                          (state_ff == RMPS_TX); // RL4 RL7
  assign rx_enable = (state_ff == RMPS_SEARCH) ||
                     (state_ff == RMPS_RECV); // RL4
  assign tx_enable = (state_ff == RMPS_TX); // RL4
  assign serial_power_on = (state_ff != RMPS_OFF); // RL7
  always_comb begin
    case (state_ff)
      RMPS_SEARCH: status_led = 1'b1;
      RMPS_RECV: status_led = 1'b0;
      RMPS_TX: status_led = tmr_ff[0];
      RMPS_SAFE: status_led = led_ff; // RL3
      RMPS_SLEEP: status_led = 1'b0; // RL19
      default: status_led = 1'b0;
    endcase
  end
  assign state = state_ff;
  assign ok_send = ok_ff;
  assign fault_valid = valid_ff && (state_ff == RMPS_SAFE); // RL2
  assign fault_code = code_ff;
  assign cpu_reboot = reboot_ff;
  assign t_min = tmin_ff;
  assign t_marg = marg;
  assign t_sleep = slp;
  assign lost_count = lost_ff;
endmodule

// *** bench/rmps_top_monitor.sv ***
module rmps_top_monitor
  import rmps_pkg::*;
#(
  parameter int MS_CYC = 10,
  parameter int TW = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic module_enable_in,
  input wire rmps_cmd_t config_command,
  input wire logic fault_in,
  input wire rmps_state_t state,
  input wire logic radio_power_on,
  input wire logic rx_enable,
  input wire logic tx_enable,
  input wire logic serial_power_on,
  input wire logic status_led,
  input wire logic ok_send,
  input wire logic [TW-1:0] t_min,
  input wire logic [TW-1:0] t_marg
);
  timeunit 1ns;
  timeprecision 1ps;
  // one extra tick of slack for the tick phase at wake entry
  localparam int OK_HI = 31 * MS_CYC + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_safe_quiet: assert property (
    state == RMPS_SAFE |-> !rx_enable && !tx_enable)
    else $error("radio active in safe mode");
  chk_sleep_power: assert property (
    state == RMPS_SLEEP |-> !radio_power_on && serial_power_on)
    else $error("wrong power in sleep");
  chk_sleep_led: assert property (
    state == RMPS_SLEEP |-> !status_led)
    else $error("indicator high in sleep");
  chk_off_hold: assert property (
    !module_enable_in [*3] |-> state == RMPS_OFF)
    else $error("not off with enable low");
  chk_on_needs_en: assert property (
    state == RMPS_OFF && !module_enable_in && !$past(module_enable_in)
    |=> state == RMPS_OFF)
    else $error("left off without enable");
  chk_fault_safe: assert property (
    fault_in && module_enable_in && state == RMPS_SEARCH
    |=> state == RMPS_SAFE)
    else $error("fault did not enter safe");
  chk_sleep_cmd: assert property (
    config_command.sleep && module_enable_in && state == RMPS_SEARCH
    |=> state == RMPS_SLEEP)
    else $error("sleep command ignored");
  chk_ok_bound: assert property (
    $rose(state == RMPS_WAKE) |-> ##[1:OK_HI] ok_send)
    else $error("no ok after wake");
  chk_ok_from_wake: assert property (
    ok_send |-> state == RMPS_WAKE || $past(state) == RMPS_WAKE)
    else $error("ok outside wake");
  chk_margin_calc: assert property (
    state == RMPS_PSAVE |-> t_marg == (t_min >> 3) + 16'h003C)
    else $error("margin wrong");
  cov_safe: cover property (state == RMPS_SAFE);
  cov_psave: cover property (state == RMPS_PSAVE);
  cov_ok: cover property (ok_send);
  cov_tx: cover property (state == RMPS_TX);
endmodule

bind rmps_top rmps_top_monitor #(.MS_CYC(MS_CYC), .TW(TW)) u_mon (
  .clk(clk), .rst_n(rst_n), .module_enable_in(module_enable_in),
  .config_command(config_command), .fault_in(fault_in), .state(state),
  .radio_power_on(radio_power_on), .rx_enable(rx_enable),
  .tx_enable(tx_enable), .serial_power_on(serial_power_on),
  .status_led(status_led), .ok_send(ok_send), .t_min(t_min),
  .t_marg(t_marg)
);

// *** bench/rmps_host_model.sv ***
module rmps_host_model (
  input wire logic clk,
  input wire logic en_req,
  input wire logic wake_req,
  input wire logic ok_send,
  output logic module_enable_in,
  output logic serial_tx_data_in,
  output logic ok_seen
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    module_enable_in = 1'b0;
    serial_tx_data_in = 1'b1;
    ok_seen = 1'b0;
  end
  always @(posedge clk) module_enable_in <= en_req;
  // low for 8 cycles, longer than the minimum pulse filter
  always @(posedge clk) begin
    if (wake_req) begin
      serial_tx_data_in <= 1'b0;
      repeat (8) @(posedge clk);
      serial_tx_data_in <= 1'b1;
    end
  end
  // ok_seen drops on a wake request and rises once ok has been seen
  always @(posedge clk) begin
    if (wake_req) ok_seen <= 1'b0;
    else if (ok_send) ok_seen <= 1'b1;
  end
endmodule

// *** bench/rmps_top_tb_top.sv ***
module rmps_top_tb_top
  import rmps_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int MS = 10;
  logic clk = 0, rst_n = 0, fault_in = 0, en_req = 0, wake_req = 0;
  logic [7:0] fault_code_in = 8'h00;
  logic [7:0] fault_code;
  rmps_radio_ev_t radio_ev = '0;
  rmps_cmd_t config_command = '0;
  rmps_state_t state;
  logic radio_power_on, rx_enable, tx_enable, serial_power_on, status_led;
  logic ok_send, fault_valid, cpu_reboot, ok_seen;
  logic module_enable_in, serial_tx_data_in;
  logic [15:0] t_min, t_marg, t_sleep, lost_count;
  int bad_count = 0, n_checks = 0, cyc_n = 0, i;
  time t0;
  always #2.5 clk = ~clk;
  rmps_top #(.MS_CYC(MS), .WAKE_CYC(4), .TW(16), .FW(8)) DUT (
    .clk(clk), .rst_n(rst_n), .module_enable_in(module_enable_in),
    .serial_tx_data_in(serial_tx_data_in), .radio_ev(radio_ev),
    .config_command(config_command), .fault_in(fault_in),
    .fault_code_in(fault_code_in), .state(state),
    .radio_power_on(radio_power_on), .rx_enable(rx_enable),
    .tx_enable(tx_enable), .serial_power_on(serial_power_on),
    .status_led(status_led), .ok_send(ok_send),
    .fault_valid(fault_valid), .fault_code(fault_code),
    .cpu_reboot(cpu_reboot), .t_min(t_min), .t_marg(t_marg),
    .t_sleep(t_sleep), .lost_count(lost_count));
  rmps_host_model u_host (.clk(clk), .en_req(en_req),
    .wake_req(wake_req), .ok_send(ok_send),
    .module_enable_in(module_enable_in),
    .serial_tx_data_in(serial_tx_data_in), .ok_seen(ok_seen));
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %0h got %0h", n, e, g);
    end
  endtask
  task automatic results;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // checks land on falling edges, where outputs have settled
  task automatic wait_st(input rmps_state_t s, input int lim);
    @(negedge clk);
    for (int k = 0; k < lim && state !== s; k++) @(negedge clk);
    chk("state", {29'h0, s}, {29'h0, state});
  endtask
  task automatic ev(input rmps_radio_ev_t e);
    @(posedge clk) radio_ev <= e;
    @(posedge clk) radio_ev <= '0;
  endtask
  task automatic cmd(input rmps_cmd_t c);
    @(posedge clk) config_command <= c;
    @(posedge clk) config_command <= '0;
  endtask
  task automatic frame;
    ev(5'h10);
    repeat (MS) @(posedge clk);
    ev(5'h0C);
  endtask
  task automatic t_rx;
    ev(5'h10);
    wait_st(RMPS_RECV, 3);
    chk("rx_enable", 1, rx_enable);
    ev(5'h0C);
    wait_st(RMPS_SEARCH, 3);
    chk("led_search", 1, status_led);
  endtask
  task automatic t_sleep_wake;
    cmd(4'h8);
    wait_st(RMPS_SLEEP, 3);
    chk("serial_power", 1, serial_power_on);
    chk("radio_power", 0, radio_power_on);
    chk("led_sleep", 0, status_led);
    repeat (50) @(posedge clk);
    wait_st(RMPS_SLEEP, 0);
    @(posedge clk) wake_req <= 1'b1;
    @(posedge clk) wake_req <= 1'b0;
    wait_st(RMPS_WAKE, 20);
    for (i = 0; i < 400 && ok_seen !== 1'b1; i++) @(negedge clk);
    chk("ok_delay", 1, i >= 30 * MS - 5 && i <= 31 * MS + 2);
    wait_st(RMPS_SEARCH, 5);
    repeat (200) @(posedge clk);
    wait_st(RMPS_SEARCH, 0);
  endtask
  task automatic t_psave;
    cmd(4'h2);
    for (int k = 0; k < 5; k++) begin
      frame();
      if (k == 3) begin
        repeat (3) @(negedge clk);
        chk("early_sleep", 0, state === RMPS_PSAVE);
      end
      if (k < 4) repeat (300 * MS - MS - 12) @(posedge clk);
    end
    wait_st(RMPS_PSAVE, 20);
    chk("t_min", 1, t_min >= 299 && t_min <= 301);
    chk("t_marg", (t_min >> 3) + 60, t_marg);
    chk("t_sleep", 1, t_sleep > 0 && t_sleep < t_min - t_marg);
    for (i = 0; i < 600 * MS && lost_count !== 16'h0001; i++)
      @(negedge clk);
    chk("lost", 1, lost_count);
    wait_st(RMPS_SEARCH, 5);
  endtask
  task automatic t_fault;
    @(posedge clk) begin
      fault_in <= 1'b1;
      fault_code_in <= 8'hA5;
    end
    @(posedge clk) fault_in <= 1'b0;
    wait_st(RMPS_SAFE, 3);
    t0 = $time;
    chk("fault_code", {23'h0, 1'b1, 8'hA5}, {fault_valid, fault_code});
    ev(5'h10);
    wait_st(RMPS_SAFE, 0);
    chk("radio_en", 0, rx_enable | tx_enable);
    repeat (125 * MS - 10) @(posedge clk);
    @(negedge clk) chk("blink0", 0, status_led);
    repeat (250 * MS) @(posedge clk);
    @(negedge clk) chk("blink1", 1, status_led);
    for (i = 0; i < 5000 * MS && cpu_reboot !== 1'b1; i++) @(negedge clk);
    i = int'(($time - t0) / 5);
    chk("reboot_at", 1, i >= 5000 * MS - 5 && i <= 5000 * MS + 5);
    wait_st(RMPS_SEARCH, 10);
  endtask
  task automatic t_restart;
    cmd(4'h4);
    for (i = 0; i < 10 && cpu_reboot !== 1'b1; i++) @(negedge clk);
    chk("restart", 1, cpu_reboot);
    wait_st(RMPS_SEARCH, 10);
  endtask
  // without a transmit scenario the safe-mode gating check could pass on a
  // transmit enable stuck low
  task automatic t_tx;
    ev(5'h02);
    wait_st(RMPS_TX, 3);
    chk("tx_enable", 1, tx_enable);
    chk("tx_rx_off", 0, rx_enable);
    ev(5'h01);
    wait_st(RMPS_SEARCH, 3);
    chk("tx_done_off", 0, tx_enable);
  endtask
  task automatic t_off;
    @(posedge clk) en_req <= 1'b0;
    wait_st(RMPS_OFF, 4);
    chk("off_power", 0, radio_power_on | fault_valid);
    chk("off_tmin", 16'hFFFF, t_min);
    chk("off_lost", 0, lost_count);
  endtask
  // a hang ends the run with a mismatch instead of stalling
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 90000) begin
      bad_count++;
      $display("BAD timeout exp %0d got %0d", 0, cyc_n);
      results();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk) chk("rst_state", 0, state);
    chk("rst_tmin", 16'hFFFF, t_min);
    @(posedge clk) rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    wait_st(RMPS_OFF, 0);
    @(posedge clk) en_req <= 1'b1;
    wait_st(RMPS_SEARCH, 6);
    t_rx();
    t_sleep_wake();
    t_psave();
    t_fault();
    t_restart();
    t_tx();
    t_off();
    results();
  end
endmodule
